// file: design/dec_dma_ep_config.sv
// dma configuration and per-index endpoint setup behind the command interface
// assumes command and data strobes come from logic on sys_clk; the end-of-transfer
// pin is asynchronous; interrupt register state and sof detection live elsewhere
`timescale 1ns/100ps

// Summary of operation
// - dma access moves one byte in default mode, two in enhanced; read and write
// - bits 1-0 pick burst: single, four, eight or sixteen cycles
// - first dma byte resets to zero: disabled, single cycle, read direction
// - bit 2 enables dma; hardware clears it when end-of-transfer asserts unless bit 4 is set
// - bit 3 direction: zero out-buffer to memory, one memory to in-buffer
// - bit 4 set restarts the transfer automatically after completion
// - bit 5 adds start-of-frame packets to the interrupt pin sources
// - default mode: bits 6 and 7 enable index four and five interrupts
// - enhanced mode: bits 6, 7 ignored; four, five enabled unless dma index
// - enhanced second byte bits 3-0 choose the single dma endpoint index
// - enhanced: sixteen endpoint config codes, one byte, bit 0 enables index
// - bits 2-1 give endpoint type; code three is reserved
// - bits 6-3 pick max packet size, fixing buffer size; resets zero
// - transfer completion sets a flag cleared by reading the interrupt register
// - sof-only mode raises interrupts on sof only, ignoring pin mode bit
module dec_dma_ep_config #(
    parameter logic [dec_pkg::EP_COUNT*dec_pkg::PKT_BYTES_W-1:0] PKT_SIZE_LUT = {
        10'h1F8, 10'h1C0, 10'h180, 10'h140, 10'h100, 10'h0C0, 10'h080, 10'h060,
        10'h040, 10'h030, 10'h020, 10'h018, 10'h010, 10'h00C, 10'h008, 10'h000
    }
) (
    input  wire logic                               sys_clk,
    input  wire logic                               reset_n,
    input  wire logic                               enhanced_mode,
    input  wire logic                               cmd_wr,
    input  wire logic                               dat_wr,
    input  wire logic                               dat_rd,
    input  wire logic [7:0]                         bus_wdata,
    output logic      [7:0]                         bus_rdata,
    input  wire logic                               transfer_done_n,
    input  wire logic                               sof_rx,
    input  wire logic                               irq_reg_pending,
    input  wire logic                               sof_only_mode,
    input  wire logic                               irq_reg_read,
    input  wire logic [3:0]                         ep_query_index,
    output dec_pkg::dec_ep_setup_t                  ep_query_setup,
    output dec_pkg::dec_dma_setup_t                 dma_setup,
    output logic                                    dma_restart,
    output logic                                    dma_eot_flag,
    output logic                                    ep_index_four_irq_en,
    output logic                                    ep_index_five_irq_en,
    output logic                                    irq_out
);

    // burst field to beat count
    function automatic logic [4:0] burst_beats(input logic [1:0] code);
        logic [4:0] beats;
        beats = dec_pkg::BEATS_SIXTEEN;
        if (code == dec_pkg::BURST_SINGLE) begin
            beats = dec_pkg::BEATS_SINGLE;
        end else if (code == dec_pkg::BURST_FOUR) begin
            beats = dec_pkg::BEATS_FOUR;
        end else if (code == dec_pkg::BURST_EIGHT) begin
            beats = dec_pkg::BEATS_EIGHT;
        end
        return beats;
    endfunction

    // packet size code to byte count
    function automatic logic [dec_pkg::PKT_BYTES_W-1:0] pkt_bytes(input logic [3:0] code);
        return PKT_SIZE_LUT[code*dec_pkg::PKT_BYTES_W +: dec_pkg::PKT_BYTES_W];
    endfunction

    // per-index interrupt gate
    // all inputs are arguments so a continuous assignment sees every change
    function automatic logic ep_irq_enable(input logic       enh,
                                           input logic [3:0] sel,
                                           input logic [3:0] index,
                                           input logic       ctrl_bit);
        logic en;
        en = ctrl_bit;
        if (enh) begin
            en = (sel != index);
        end
        return en;
    endfunction

    dec_pkg::dec_dma_ctrl_t ctrl;
    dec_pkg::dec_dma_ctrl_t next_ctrl;
    logic [3:0]             ep_sel;
    logic [3:0]             next_ep_sel;
    dec_pkg::dec_cmd_kind_t cmd_kind;
    dec_pkg::dec_cmd_kind_t next_cmd_kind;
    logic [3:0]             cmd_ep_index;
    logic [1:0]             byte_idx;
    logic [1:0]             next_byte_idx;
    logic [7:0]             next_rdata;
    logic                   done_meta;
    logic                   done_sync;
    logic                   done_prev;
    logic                   next_irq;

    // decode of the current command and data phase
    wire logic       cmd_is_dma;
    wire logic       cmd_is_ep_cfg;
    wire logic [1:0] dma_byte_limit;
    wire logic       data_access;
    wire logic       dma_phase;
    wire logic       ep_cfg_phase;
    wire logic       dma_first;
    wire logic       dma_second;
    wire logic       ep_cfg_write;
    wire logic       eot_event;
    wire logic       user_ctrl_write;
    wire logic [7:0] ep_cfg_raw;
    dec_pkg::dec_ep_cfg_t ep_cfg_wr;
    dec_pkg::dec_ep_cfg_t ep_cfg_rd;

    assign cmd_is_dma    = (bus_wdata == dec_pkg::CMD_SET_DMA);
    assign cmd_is_ep_cfg = (bus_wdata[7:4] == dec_pkg::CMD_EP_CFG_GROUP) && enhanced_mode;

    assign dma_byte_limit = enhanced_mode ? dec_pkg::DMA_BYTES_ENHANCED : dec_pkg::DMA_BYTES_DEFAULT;
    assign data_access    = dat_wr || dat_rd;
    assign dma_phase      = (cmd_kind == dec_pkg::CMD_DMA) && (byte_idx < dma_byte_limit);
    assign ep_cfg_phase   = (cmd_kind == dec_pkg::CMD_EP_CFG) && (byte_idx < dec_pkg::EP_CFG_BYTES);
    assign dma_first      = dma_phase && (byte_idx == dec_pkg::BYTE_FIRST);
    assign dma_second     = dma_phase && (byte_idx == dec_pkg::BYTE_SECOND);

    // one written byte per endpoint code
    assign ep_cfg_write   = ep_cfg_phase && dat_wr;
    assign user_ctrl_write = dma_first && dat_wr;

    // end-of-transfer assertion seen as a falling edge after the synchroniser
    assign eot_event = done_prev && !done_sync;

    always_comb begin
        next_cmd_kind = cmd_kind;
        if (cmd_wr) begin
            if (cmd_is_dma) begin
                next_cmd_kind = dec_pkg::CMD_DMA;
            end else if (cmd_is_ep_cfg) begin
                next_cmd_kind = dec_pkg::CMD_EP_CFG;
            end else begin
                next_cmd_kind = dec_pkg::CMD_OTHER;
            end
        end
    end

    always_comb begin
        next_byte_idx = byte_idx;
        if (cmd_wr) begin
            next_byte_idx = dec_pkg::BYTE_FIRST;
        end else if (data_access && (dma_phase || ep_cfg_phase)) begin
            next_byte_idx = byte_idx + 2'h1;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        // hardware clear on end of transfer
        if (eot_event) begin
            // auto reload keeps the engine armed
            next_ctrl.enable = ctrl.auto_reload;
        end
        // software write of the first byte
        if (user_ctrl_write) begin
            next_ctrl = bus_wdata;
        end
    end

    always_comb begin
        next_ep_sel = ep_sel;
        // enhanced second byte picks the dma index
        if (dma_second && dat_wr) begin
            next_ep_sel = bus_wdata[3:0];
        end
    end

    always_comb begin
        next_rdata = bus_rdata;
        if (dat_rd) begin
            next_rdata = dec_pkg::READ_IDLE;
            if (dma_first) begin
                next_rdata = ctrl;
            end else if (dma_second) begin
                next_rdata = {dec_pkg::SEL_PAD, ep_sel};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl      <= dec_pkg::CTRL_RESET;
            ep_sel    <= dec_pkg::EP_SEL_RESET;
            cmd_kind  <= dec_pkg::CMD_NONE;
            byte_idx  <= dec_pkg::BYTE_FIRST;
            bus_rdata <= dec_pkg::READ_IDLE;
        end else begin
            ctrl      <= next_ctrl;
            ep_sel    <= next_ep_sel;
            cmd_kind  <= next_cmd_kind;
            byte_idx  <= next_byte_idx;
            bus_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ep_index <= dec_pkg::EP_SEL_RESET;
        end else if (cmd_wr) begin
            cmd_ep_index <= bus_wdata[3:0];
        end
    end

    // pin synchroniser; idle high so reset does not fake an assertion
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_meta <= 1'b1;
            done_sync <= 1'b1;
            done_prev <= 1'b1;
        end else begin
            done_meta <= transfer_done_n;
            done_sync <= done_meta;
            done_prev <= done_sync;
        end
    end

    // sticky completion flag, set beats the read clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dma_eot_flag <= 1'b0;
        end else if (eot_event) begin
            dma_eot_flag <= 1'b1;
        end else if (irq_reg_read) begin
            dma_eot_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dma_restart <= 1'b0;
        end else begin
            dma_restart <= eot_event && ctrl.enable && ctrl.auto_reload && !user_ctrl_write;
        end
    end

    // sof-only mode overrides the pin mode bit
    always_comb begin
        if (sof_only_mode) begin
            next_irq = sof_rx;
        end else begin
            next_irq = irq_reg_pending || dma_eot_flag || (ctrl.sof_pin_mode && sof_rx);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

    // index four and five interrupt gating
    assign ep_index_four_irq_en = ep_irq_enable(enhanced_mode, ep_sel, dec_pkg::EP_INDEX_FOUR, ctrl.ep4_irq_en);
    assign ep_index_five_irq_en = ep_irq_enable(enhanced_mode, ep_sel, dec_pkg::EP_INDEX_FIVE, ctrl.ep5_irq_en);

    assign dma_setup.enable       = ctrl.enable;
    assign dma_setup.to_in_buffer = ctrl.to_in_buffer;
    assign dma_setup.auto_reload  = ctrl.auto_reload;
    assign dma_setup.burst_beats  = burst_beats(ctrl.burst);
    assign dma_setup.ep_index     = enhanced_mode ? ep_sel : dec_pkg::EP_SEL_RESET;

    // reserved bit stored as zero whatever the host writes
    assign ep_cfg_wr.reserved     = 1'b0;
    assign ep_cfg_wr.max_pkt_code = bus_wdata[6:3];
    assign ep_cfg_wr.ep_type      = bus_wdata[2:1];
    assign ep_cfg_wr.ep_enable    = bus_wdata[0];

    dec_ep_mem #(
        .DEPTH     (dec_pkg::EP_COUNT),
        .WIDTH     (8),
        .ADDR_W    (dec_pkg::EP_IDX_W),
        .RESET_VAL (dec_pkg::EP_CFG_RESET)
    ) u_ep_mem (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr_en   (ep_cfg_write),
        .wr_addr (cmd_ep_index),
        .wr_data (ep_cfg_wr),
        .rd_addr (ep_query_index),
        .rd_data (ep_cfg_raw)
    );

    assign ep_cfg_rd = ep_cfg_raw;

    assign ep_query_setup.ep_enable     = ep_cfg_rd.ep_enable;
    assign ep_query_setup.ep_type       = ep_cfg_rd.ep_type;
    assign ep_query_setup.type_illegal  = (ep_cfg_rd.ep_type == dec_pkg::EP_TYPE_RESERVED);
    assign ep_query_setup.max_pkt_bytes = pkt_bytes(ep_cfg_rd.max_pkt_code);

endmodule // dec_dma_ep_config

// file: pkg/dec_pkg.sv
// shared constants and types for the dma and endpoint configuration block
// assumes a byte-wide command interface driven by a local microcontroller
package dec_pkg;

    // command codes
    localparam logic [7:0] CMD_SET_DMA      = 8'hFB;
    localparam logic [7:0] CMD_EP_CFG_BASE  = 8'hB0;
    localparam logic [3:0] CMD_EP_CFG_GROUP = 4'hB;

    // data phase limits
    localparam logic [1:0] DMA_BYTES_DEFAULT  = 2'h1;
    localparam logic [1:0] DMA_BYTES_ENHANCED = 2'h2;
    localparam logic [1:0] EP_CFG_BYTES       = 2'h1;

    // byte positions in the data phase
    localparam logic [1:0] BYTE_FIRST  = 2'h0;
    localparam logic [1:0] BYTE_SECOND = 2'h1;

    // endpoint indices whose interrupts the control byte gates
    localparam logic [3:0] EP_INDEX_FOUR = 4'h4;
    localparam logic [3:0] EP_INDEX_FIVE = 4'h5;

    localparam int EP_COUNT      = 16;
    localparam int EP_IDX_W      = 4;
    localparam int PKT_BYTES_W   = 10;

    // reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [3:0] EP_SEL_RESET = 4'h0;
    localparam logic [7:0] EP_CFG_RESET = 8'h00;
    localparam logic [3:0] SEL_PAD      = 4'h0;
    localparam logic [7:0] READ_IDLE    = 8'h00;

    // burst field codes and beat counts
    localparam logic [1:0] BURST_SINGLE = 2'h0;
    localparam logic [1:0] BURST_FOUR   = 2'h1;
    localparam logic [1:0] BURST_EIGHT  = 2'h2;
    localparam logic [4:0] BEATS_SINGLE  = 5'h01;
    localparam logic [4:0] BEATS_FOUR    = 5'h04;
    localparam logic [4:0] BEATS_EIGHT   = 5'h08;
    localparam logic [4:0] BEATS_SIXTEEN = 5'h10;

    // endpoint type codes
    localparam logic [1:0] EP_TYPE_CONTROL  = 2'h0;
    localparam logic [1:0] EP_TYPE_BULK_INT = 2'h1;
    localparam logic [1:0] EP_TYPE_ISO      = 2'h2;
    localparam logic [1:0] EP_TYPE_RESERVED = 2'h3;

    // first dma byte, msb first
    typedef struct packed {
        logic       ep5_irq_en;
        logic       ep4_irq_en;
        logic       sof_pin_mode;
        logic       auto_reload;
        logic       to_in_buffer;
        logic       enable;
        logic [1:0] burst;
    } dec_dma_ctrl_t;

    // endpoint configuration byte, msb first
    typedef struct packed {
        logic       reserved;
        logic [3:0] max_pkt_code;
        logic [1:0] ep_type;
        logic       ep_enable;
    } dec_ep_cfg_t;

    // decoded dma settings handed to the transfer engine
    typedef struct packed {
        logic       enable;
        logic       to_in_buffer;
        logic       auto_reload;
        logic [4:0] burst_beats;
        logic [3:0] ep_index;
    } dec_dma_setup_t;

    // decoded endpoint setup for one index
    typedef struct packed {
        logic                   ep_enable;
        logic [1:0]             ep_type;
        logic                   type_illegal;
        logic [PKT_BYTES_W-1:0] max_pkt_bytes;
    } dec_ep_setup_t;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_DMA,
        CMD_EP_CFG,
        CMD_OTHER
    } dec_cmd_kind_t;

endpackage

// file: design/dec_ep_mem.sv
// small register file holding one endpoint configuration byte per index
// assumes a single writer; read data are registered, one cycle after the address
`timescale 1ns/100ps
module dec_ep_mem #(
    parameter int         DEPTH     = 16,
    parameter int         WIDTH     = 8,
    parameter int         ADDR_W    = 4,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);

    logic [WIDTH-1:0] store [DEPTH];

    // flops rather than ram so every entry resets to a known value
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= RESET_VAL[WIDTH-1:0];
            end
        end else if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= RESET_VAL[WIDTH-1:0];
        end else begin
            rd_data <= store[rd_addr];
        end
    end

endmodule // dec_ep_mem

// file: tb/dec_dma_ep_chk.sv
// assertions on the ports of the dma and endpoint configuration block
// assumes one clock, async low reset, strobes launched between rising edges
`timescale 1ns/100ps
module dec_dma_ep_chk (
    input wire logic                    sys_clk,
    input wire logic                    reset_n,
    input wire logic                    enhanced_mode,
    input wire logic                    cmd_wr,
    input wire logic                    dat_wr,
    input wire logic [7:0]              bus_wdata,
    input wire logic                    transfer_done_n,
    input wire logic                    sof_rx,
    input wire logic                    irq_reg_pending,
    input wire logic                    sof_only_mode,
    input wire logic                    irq_reg_read,
    input wire dec_pkg::dec_ep_setup_t  ep_query_setup,
    input wire dec_pkg::dec_dma_setup_t dma_setup,
    input wire logic                    dma_restart,
    input wire logic                    dma_eot_flag,
    input wire logic                    ep_index_four_irq_en,
    input wire logic                    ep_index_five_irq_en,
    input wire logic                    irq_out
);
    localparam logic [19:0] BEATS = 20'h82081;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_ctrl_wr;
        cmd_wr && bus_wdata == 8'hFB ##1 dat_wr;
    endsequence
    sequence s_sel_wr;
        s_ctrl_wr ##1 dat_wr;
    endsequence
    // the pin is synchronised, so the reaction lands a few edges late
    sequence s_pin_fall;
        $fell(transfer_done_n);
    endsequence
    a_burst_decode: assert property (s_ctrl_wr |=>
        dma_setup.burst_beats == BEATS[$past(bus_wdata[1:0])*5 +: 5]) else $error("burst beats wrong");
    a_ctrl_fields: assert property (s_ctrl_wr |=> dma_setup.enable == $past(bus_wdata[2]) &&
        dma_setup.to_in_buffer == $past(bus_wdata[3]) && dma_setup.auto_reload == $past(bus_wdata[4]))
        else $error("control fields wrong");
    a_index_select: assert property (s_sel_wr |=>
        !enhanced_mode || dma_setup.ep_index == $past(bus_wdata[3:0])) else $error("dma index wrong");
    a_eot_clear: assert property (s_pin_fall ##0 dma_setup.enable && !dma_setup.auto_reload
        |-> ##[2:5] !dma_setup.enable) else $error("enable not cleared");
    a_auto_restart: assert property (s_pin_fall ##0 dma_setup.enable && dma_setup.auto_reload
        |-> ##[2:5] dma_restart ##1 !dma_restart) else $error("no restart pulse");
    a_eot_flag_set: assert property (s_pin_fall |-> ##[2:5] dma_eot_flag) else $error("flag not set");
    a_eot_flag_clear: assert property (irq_reg_read && transfer_done_n && $past(transfer_done_n) &&
        $past(transfer_done_n, 2) && $past(transfer_done_n, 3) |=> !dma_eot_flag) else $error("flag stuck");
    a_irq_sources: assert property (!sof_only_mode && (irq_reg_pending || dma_eot_flag) |=> irq_out)
        else $error("irq missing");
    a_irq_quiet: assert property (!sof_only_mode && !irq_reg_pending && !dma_eot_flag && !sof_rx
        |=> !irq_out) else $error("spurious irq");
    a_sof_only: assert property (sof_only_mode |=> irq_out == $past(sof_rx)) else $error("sof only");
    a_enh_ep_irq: assert property (enhanced_mode |->
        ep_index_four_irq_en == (dma_setup.ep_index != 4'h4) &&
        ep_index_five_irq_en == (dma_setup.ep_index != 4'h5)) else $error("ep irq enables");
    a_type_flag: assert property (ep_query_setup.type_illegal == (ep_query_setup.ep_type == 2'h3))
        else $error("type flag");
endmodule // dec_dma_ep_chk
bind dec_dma_ep_config dec_dma_ep_chk dec_dma_ep_chk_inst (.sys_clk, .reset_n, .enhanced_mode, .cmd_wr,
    .dat_wr, .bus_wdata, .transfer_done_n, .sof_rx, .irq_reg_pending, .sof_only_mode, .irq_reg_read,
    .ep_query_setup, .dma_setup, .dma_restart, .dma_eot_flag, .ep_index_four_irq_en,
    .ep_index_five_irq_en, .irq_out);

// file: tb/dec_dma_agent.sv
// behavioural dma agent: runs while enabled, then ends with a low pulse
// assumes the configuration block's dma_setup and restart outputs
`timescale 1ns/100ps
module dec_dma_agent (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire dec_pkg::dec_dma_setup_t dma_setup,
    input  wire logic                    dma_restart,
    input  wire logic [7:0]              delay,
    output logic                         transfer_done_n
);
    logic [7:0] cnt;
    logic [1:0] low;
    logic       done;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
            low <= 2'h0;
            done <= 1'b0;
            transfer_done_n <= 1'b1;
        end else begin
            // three low cycles so the synchroniser cannot miss it
            transfer_done_n <= (low == 2'h0);
            if (low != 2'h0) low <= low - 2'h1;
            if (!dma_setup.enable || dma_restart) begin
                cnt <= 8'h00;
                done <= 1'b0;
            end else if (!done && cnt == delay) begin
                low <= 2'h3;
                done <= 1'b1;
            end else if (!done) cnt <= cnt + 8'h01;
        end
    end
endmodule // dec_dma_agent

// file: tb/dma_and_endpoint_config_test.sv
// testbench: command bus tasks, dma agent model, expected values from rules
// assumes the design and its checker bind are compiled first
`timescale 1ns/100ps
module dma_and_endpoint_config_test;
    localparam logic [159:0] LUT = {10'h3FF, 10'h200, 10'h1F8, 10'h100, 10'h0C0, 10'h080, 10'h040, 10'h030,
        10'h020, 10'h018, 10'h010, 10'h00C, 10'h008, 10'h004, 10'h002, 10'h001};
    localparam logic [19:0] BT = 20'h82081;
    logic sys_clk = 0, reset_n = 0, enhanced_mode = 0, cmd_wr = 0, dat_wr = 0, dat_rd = 0;
    logic sof_rx = 0, irq_reg_pending = 0, sof_only_mode = 0, irq_reg_read = 0;
    logic transfer_done_n, dma_restart, dma_eot_flag, ep_index_four_irq_en, ep_index_five_irq_en, irq_out;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, rdq, v, delay = 8'h05;
    logic [3:0] ep_query_index = 4'h0;
    dec_pkg::dec_ep_setup_t  ep_query_setup;
    dec_pkg::dec_dma_setup_t dma_setup;
    int failures = 0, n_tests = 0, cycles = 0, i, k;
    always #12.5 sys_clk = ~sys_clk;
    dec_dma_ep_config #(.PKT_SIZE_LUT(LUT)) dec_dma_ep_config_inst (.sys_clk, .reset_n, .enhanced_mode,
        .cmd_wr, .dat_wr, .dat_rd, .bus_wdata, .bus_rdata, .transfer_done_n, .sof_rx, .irq_reg_pending,
        .sof_only_mode, .irq_reg_read, .ep_query_index, .ep_query_setup, .dma_setup, .dma_restart,
        .dma_eot_flag, .ep_index_four_irq_en, .ep_index_five_irq_en, .irq_out);
    dec_dma_agent dec_dma_agent_inst (.sys_clk, .reset_n, .dma_setup, .dma_restart, .delay, .transfer_done_n);
    task finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // every strobe is set once per falling edge, so back-to-back calls are safe
    task bus(input logic c, input logic w, input logic r, input logic [7:0] d);
        @(negedge sys_clk);
        rdq = bus_rdata;
        cmd_wr = c;
        dat_wr = w;
        dat_rd = r;
        bus_wdata = d;
    endtask
    task idle(input int n);
        repeat (n) bus(0, 0, 0, 8'h00);
    endtask
    task ctrl(input logic [7:0] d);
        bus(1, 0, 0, 8'hFB);
        bus(0, 1, 0, d);
        idle(1);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1;
        ep_query_index = 4'h9;
        idle(2);
        check("dma_setup", dma_setup, {3'h0, 5'h01, 4'h0});
        check("ep reset", ep_query_setup, {4'h0, LUT[9:0]});
        check("ep4 irq", ep_index_four_irq_en, 1'b0);
        for (i = 0; i < 4; i++) begin
            v = {i[0], i[1], 1'b0, i[1], i[0], 1'b0, i[1:0]};
            ctrl(v);
            bus(0, 1, 0, 8'hFF);
            check("beats", dma_setup.burst_beats, BT[i*5 +: 5]);
            check("dir", dma_setup.to_in_buffer, v[3]);
            check("reload", dma_setup.auto_reload, v[4]);
            check("irq en", {ep_index_five_irq_en, ep_index_four_irq_en}, v[7:6]);
            bus(1, 0, 0, 8'hFB);
            bus(0, 0, 1, 8'h00);
            bus(0, 0, 1, 8'h00);
            check("rd byte1", rdq, v);
            idle(1);
            check("rd byte2", rdq, 8'h00);
        end
        enhanced_mode = 1;
        bus(1, 0, 0, 8'hFB);
        bus(0, 1, 0, 8'hC0);
        bus(0, 1, 0, 8'h04);
        bus(0, 1, 0, 8'h09);
        idle(1);
        check("dma index", dma_setup.ep_index, 4'h4);
        check("enh irq en", {ep_index_five_irq_en, ep_index_four_irq_en}, 2'h2);
        bus(1, 0, 0, 8'hFB);
        bus(0, 0, 1, 8'h00);
        bus(0, 0, 1, 8'h00);
        check("enh byte1", rdq, 8'hC0);
        bus(0, 0, 1, 8'h00);
        check("enh byte2", rdq, 8'h04);
        idle(1);
        check("enh byte3", rdq, 8'h00);
        for (i = 0; i < 16; i++) begin
            v = {1'b0, i[3:0], i[1:0], ~i[0]};
            bus(1, 0, 0, 8'hB0 | i[7:0]);
            bus(0, 1, 0, v);
            ep_query_index = i[3:0];
            idle(2);
            check("ep cfg", ep_query_setup, {~i[0], i[1:0], i[1:0] == 2'h3, LUT[i*10 +: 10]});
        end
        // leave a nonzero byte on the read port so a stale answer shows
        bus(1, 0, 0, 8'hFB);
        bus(0, 0, 1, 8'h00);
        bus(1, 0, 0, 8'hB5);
        bus(0, 0, 1, 8'h00);
        idle(1);
        check("ep cfg read", rdq, 8'h00);
        enhanced_mode = 0;
        ep_query_index = 4'h2;
        bus(1, 0, 0, 8'hB2);
        bus(0, 1, 0, 8'h00);
        idle(2);
        check("ep default", ep_query_setup, {3'h6, 1'b0, LUT[29:20]});
        ctrl(8'h04);
        for (k = 0; k < 60 && dma_eot_flag !== 1'b1; k++) idle(1);
        check("eot flag", dma_eot_flag, 1'b1);
        check("enable", dma_setup.enable, 1'b0);
        idle(1);
        check("irq eot", irq_out, 1'b1);
        irq_reg_read = 1;
        idle(1);
        irq_reg_read = 0;
        idle(1);
        check("flag clr", dma_eot_flag, 1'b0);
        ctrl(8'h14);
        for (k = 0; k < 60 && dma_restart !== 1'b1; k++) idle(1);
        check("restart", dma_restart, 1'b1);
        check("still on", dma_setup.enable, 1'b1);
        ctrl(8'h00);
        irq_reg_read = 1;
        idle(1);
        irq_reg_read = 0;
        ctrl(8'h20);
        sof_rx = 1;
        idle(1);
        sof_rx = 0;
        check("sof pin", irq_out, 1'b1);
        ctrl(8'h00);
        sof_rx = 1;
        idle(1);
        sof_rx = 0;
        check("sof off", irq_out, 1'b0);
        sof_only_mode = 1;
        irq_reg_pending = 1;
        idle(2);
        check("sof only", irq_out, 1'b0);
        sof_rx = 1;
        idle(1);
        sof_rx = 0;
        check("sof only hit", irq_out, 1'b1);
        finish_test();
    end
endmodule // dma_and_endpoint_config_test
